// file: hw/lpic_defs.svh
/*
 * lpic_defs.svh: register offsets, field positions, reset values and timing
 * counts of the level priority interrupt and context block.
 * Assumes: included by bare name from design files; holds definitions only.
 */
`ifndef LPIC_DEFS_SVH
`define LPIC_DEFS_SVH

// register map, byte addresses on the AXI4-Lite slave
`define LPIC_A_LVL_SET   8'h00
`define LPIC_A_LVL_CLR   8'h04
`define LPIC_A_CUR_LVL   8'h08
`define LPIC_A_INT_FLAGS 8'h0C
`define LPIC_A_CTRL      8'h10
`define LPIC_A_IDENT     8'h14
`define LPIC_A_REG_PTR   8'h18
`define LPIC_A_REG_DATA  8'h1C

// per-level register slots inside one working set
`define LPIC_R_STS 3'h0
`define LPIC_R_D   3'h1
`define LPIC_R_P   3'h2
`define LPIC_R_B   3'h3
`define LPIC_R_L   3'h4
`define LPIC_R_A   3'h5
`define LPIC_R_T   3'h6
`define LPIC_R_X   3'h7

// fixed level numbers
`define LPIC_LVL_VEC_LO 4'hA
`define LPIC_LVL_INT    4'hE
`define LPIC_LVL_TOP    4'hF

// internal condition flag positions
`define LPIC_F_SUPERVISOR_CALL  0
`define LPIC_F_PROTECT_VIOL     1
`define LPIC_F_PAGE_FAULT       2
`define LPIC_F_ILLEGAL_OPCODE   3
`define LPIC_F_ERROR_IND        4
`define LPIC_F_PRIVILEGED_OP    5
`define LPIC_F_IO_NO_RESPONSE   6
`define LPIC_F_PARITY_ERROR     7
`define LPIC_F_ADDR_RANGE_TMO   8
`define LPIC_F_SUPPLY_FAILURE   9

// field positions
`define LPIC_CTRL_SBE_EN   0
`define LPIC_ID_VALID      16
`define LPIC_ID_BUSY       31

// reset values
`define LPIC_RST_ACT  16'h0000
`define LPIC_RST_CTRL 1'b0

// context switch time and its cycle count at the core clock
`define LPIC_SWITCH_NS 1000
`define LPIC_CLK_MHZ   50
`define LPIC_SWITCH_CYC ((`LPIC_SWITCH_NS * `LPIC_CLK_MHZ) / 1000)

`endif

// file: hw/lpic_pkg.sv
/*
 * lpic_pkg: types of the level priority interrupt and context block.
 * Assumes: nothing; used by scoped name only.
 */
package lpic_pkg;

    // one core request per cycle against the working set
    typedef enum logic [3:0] {
        C_NONE,
        C_WRITE,
        C_SEQ,
        C_BRANCH,
        C_JSR,
        C_DSHL,
        C_DSHR,
        C_EA_PRE,
        C_EA_POST,
        C_IOX_OUT,
        C_IOX_IN
    } lpic_op_e;

    typedef struct packed {
        lpic_op_e op;
        logic [2:0] sel;
        logic [15:0] data;
    } lpic_core_cmd_s;

endpackage : lpic_pkg

// file: hw/lpic_top.sv
/*
 * lpic_top: sixteen-level priority interrupt system with a private set of
 * eight registers per level, internal condition flags, vectored query of
 * I/O interfaces and an AXI4-Lite register slave.
 * Assumes: core requests and internal conditions are on aclk; I/O request
 * and answer pins are asynchronous; ident_code is stable while ident_ack.
 */
// Contract
// - sixteen priority levels; activation selects running level
// - each level owns eight private registers
// - level change only swaps working set, fast
// - software may activate any level directly
// - levels ten to thirteen take vectored I/O requests
// - query returns identity of requesting interface
// - level fourteen serves internal error conditions
// - level fifteen has one external source
// - ten distinct internal conditions recognised
// - multi-bit memory error interrupts on level fourteen
// - single-bit error reported only when enabled
// - pointer auto-advances, branches, stays loadable
// - subroutine jump stores return in link
// - double extension chains with accumulator shifting
// - base before indirection, index after
// - accumulator is the programmed I/O register
// - I/O register address from low eleven bits
`timescale 1ns/1ps
`include "lpic_defs.svh"

module lpic_top #(
    parameter int ADDR_W = 8,
    parameter int NVEC = 4
) (
    input wire logic aclk,                         // core clock, 50 MHz
    input wire logic aresetn,                      // synchronous reset
    input wire logic [ADDR_W-1:0] s_axi_awaddr,    // write address
    input wire logic s_axi_awvalid,                // write address valid
    output logic s_axi_awready,                    // write address ready
    input wire logic [31:0] s_axi_wdata,           // write data
    input wire logic [3:0] s_axi_wstrb,            // byte enables
    input wire logic s_axi_wvalid,                 // write data valid
    output logic s_axi_wready,                     // write data ready
    output logic [1:0] s_axi_bresp,                // write response
    output logic s_axi_bvalid,                     // write response valid
    input wire logic s_axi_bready,                 // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr,    // read address
    input wire logic s_axi_arvalid,                // read address valid
    output logic s_axi_arready,                    // read address ready
    output logic [31:0] s_axi_rdata,               // read data
    output logic [1:0] s_axi_rresp,                // read response
    output logic s_axi_rvalid,                     // read data valid
    input wire logic s_axi_rready,                 // read data ready
    input wire lpic_pkg::lpic_core_cmd_s core_cmd, // core request
    input wire logic [9:0] int_cond,               // internal condition pulses
    input wire logic mem_mbe,                      // multi-bit memory error
    input wire logic mem_sbe,                      // corrected single-bit error
    input wire logic [NVEC-1:0] io_irq,            // vectored requests, 10..13
    input wire logic top_irq,                      // single source of level 15
    input wire logic ident_ack,                    // interface answers query
    input wire logic [8:0] ident_code,             // identity of requester
    input wire logic [15:0] io_rdata,              // data from interface
    output logic [3:0] cur_lvl,                    // running level
    output logic lvl_switch,                       // pulse on level change
    output logic [15:0] core_rdata,                // selected working register
    output logic [15:0] ea_out,                    // address arithmetic result
    output logic [10:0] io_reg_addr,               // interface register address
    output logic [15:0] io_wdata,                  // accumulator to interface
    output logic io_strobe,                        // pulse per I/O transfer
    output logic ident_req,                        // query to interfaces
    output logic [1:0] ident_lvl                   // vectored level queried
);
    localparam int SW_MAX = `LPIC_SWITCH_CYC;
    localparam int NSYNC = NVEC + 2;

    function automatic logic [6:0] ix(input logic [3:0] l, input logic [2:0] r);
        return {l, r};
    endfunction : ix

    function automatic logic [3:0] prio(input logic [15:0] act);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 1; i < 16; i++) begin
            if (act[i]) begin
                p = 4'(i);
            end
        end
        return p;
    endfunction : prio

    // ---------------- pin synchronisers ----------------
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, filt_q;
    wire [NSYNC-1:0] pins_w = {ident_ack, top_irq, io_irq};
    wire [NSYNC-1:0] agree_w = ~(s2_q ^ s3_q);
    wire [NSYNC-1:0] filt_d = (agree_w & s3_q) | (~agree_w & filt_q);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end else begin
            s1_q <= pins_w;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end
    wire [NVEC-1:0] vec_f = filt_q[NVEC-1:0];
    wire top_f = filt_q[NVEC];
    wire ack_f = filt_q[NVEC+1];

    // ---------------- AXI4-Lite slave ----------------
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_got_q, w_got_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    wire aw_hs = s_axi_awvalid & awready_q;
    wire w_hs = s_axi_wvalid & wready_q;
    wire ar_hs = s_axi_arvalid & arready_q;
    wire wr_go = aw_got_q & w_got_q & ~bvalid_q;
    wire [15:0] be16 = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [15:0] wd16 = wdata_q[15:0] & be16;
    wire wr_set = wr_go && awaddr_q == `LPIC_A_LVL_SET;
    wire wr_clr = wr_go && awaddr_q == `LPIC_A_LVL_CLR;
    wire wr_flag = wr_go && awaddr_q == `LPIC_A_INT_FLAGS;
    wire wr_ctrl = wr_go && awaddr_q == `LPIC_A_CTRL;
    wire wr_ident = wr_go && awaddr_q == `LPIC_A_IDENT;
    wire wr_ptr = wr_go && awaddr_q == `LPIC_A_REG_PTR;
    wire wr_data = wr_go && awaddr_q == `LPIC_A_REG_DATA;
    wire wr_ok = wr_set | wr_clr | wr_flag | wr_ctrl | wr_ident | wr_ptr | wr_data
        | (wr_go && awaddr_q == `LPIC_A_CUR_LVL);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                awready_q <= 1'b0;
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wready_q <= 1'b0;
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? 2'h0 : 2'h2;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // ---------------- level activation and priority ----------------
    logic [15:0] act_q;
    logic [3:0] cur_q;
    logic switch_q;
    logic [9:0] flags_q;
    logic sbe_en_q;
    wire [15:0] hw_set = {top_f, |flags_q, vec_f, 10'h0};
    wire [15:0] act_d = (act_q & ~(wr_clr ? wd16 : 16'h0))
        | (wr_set ? wd16 : 16'h0) | hw_set;
    wire [3:0] cur_d = prio(act_q);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_q <= `LPIC_RST_ACT;
            cur_q <= 4'h0;
            switch_q <= 1'b0;
        end else begin
            act_q <= act_d;
            cur_q <= cur_d;
            switch_q <= cur_d != cur_q;
        end
    end

    // ---------------- internal condition flags ----------------
    wire [9:0] mem_set = (10'(mem_mbe) | 10'(mem_sbe & sbe_en_q)) << `LPIC_F_PARITY_ERROR;
    wire [9:0] flag_clr = wr_flag ? wd16[9:0] : 10'h0;
    wire [9:0] flags_d = (flags_q & ~flag_clr) | int_cond | mem_set;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= 10'h0;
            sbe_en_q <= `LPIC_RST_CTRL;
        end else begin
            flags_q <= flags_d;
            if (wr_ctrl && wstrb_q[0]) begin
                sbe_en_q <= wdata_q[`LPIC_CTRL_SBE_EN];
            end
        end
    end

    // ---------------- vectored identity query ----------------
    logic id_req_q, id_busy_q, id_valid_q;
    logic [1:0] id_lvl_q;
    logic [8:0] id_code_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            id_req_q <= 1'b0;
            id_busy_q <= 1'b0;
            id_valid_q <= 1'b0;
            id_lvl_q <= 2'h0;
            id_code_q <= 9'h0;
        end else if (wr_ident && !id_busy_q && !ack_f) begin
            id_req_q <= 1'b1;
            id_busy_q <= 1'b1;
            id_valid_q <= 1'b0;
            id_lvl_q <= wdata_q[1:0];
        end else if (id_busy_q && ack_f) begin
            id_req_q <= 1'b0;
            id_busy_q <= 1'b0;
            id_valid_q <= 1'b1;
            id_code_q <= ident_code;
        end
    end

    // ---------------- per-level register file ----------------
    logic [15:0] regs_q [0:127];
    logic [6:0] ptr_q;
    wire [15:0] p_w = regs_q[ix(cur_q, `LPIC_R_P)];
    wire [15:0] a_w = regs_q[ix(cur_q, `LPIC_R_A)];
    wire [15:0] d_w = regs_q[ix(cur_q, `LPIC_R_D)];
    wire [15:0] b_w = regs_q[ix(cur_q, `LPIC_R_B)];
    wire [15:0] x_w = regs_q[ix(cur_q, `LPIC_R_X)];
    wire [15:0] ptr_w = regs_q[ptr_q];
    wire [15:0] data_m = (ptr_w & ~be16) | wd16;
    wire [15:0] p_next = 16'(p_w + 16'h1);
    lpic_pkg::lpic_op_e op_w;
    assign op_w = core_cmd.op;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 128; i++) begin
                regs_q[i] <= 16'h0;
            end
            ptr_q <= 7'h0;
        end else begin
            if (wr_ptr) begin
                ptr_q <= wdata_q[6:0];
            end
            if (wr_data) begin
                regs_q[ptr_q] <= data_m;
            end
            case (op_w)
                lpic_pkg::C_WRITE: begin
                    regs_q[ix(cur_q, core_cmd.sel)] <= core_cmd.data;
                end
                lpic_pkg::C_SEQ: begin
                    regs_q[ix(cur_q, `LPIC_R_P)] <= p_next;
                end
                lpic_pkg::C_BRANCH: begin
                    regs_q[ix(cur_q, `LPIC_R_P)] <= core_cmd.data;
                end
                lpic_pkg::C_JSR: begin
                    regs_q[ix(cur_q, `LPIC_R_L)] <= p_next;
                    regs_q[ix(cur_q, `LPIC_R_P)] <= core_cmd.data;
                end
                lpic_pkg::C_DSHL: begin
                    regs_q[ix(cur_q, `LPIC_R_A)] <= {a_w[14:0], d_w[15]};
                    regs_q[ix(cur_q, `LPIC_R_D)] <= {d_w[14:0], 1'b0};
                end
                lpic_pkg::C_DSHR: begin
                    regs_q[ix(cur_q, `LPIC_R_A)] <= {1'b0, a_w[15:1]};
                    regs_q[ix(cur_q, `LPIC_R_D)] <= {a_w[0], d_w[15:1]};
                end
                lpic_pkg::C_IOX_IN: begin
                    regs_q[ix(cur_q, `LPIC_R_A)] <= io_rdata;
                end
                default: begin
                end
            endcase
        end
    end

    // ---------------- core-side outputs ----------------
    logic [15:0] core_rd_q, ea_q, io_wd_q;
    logic [10:0] io_addr_q;
    logic io_stb_q;
    wire io_op = op_w == lpic_pkg::C_IOX_OUT || op_w == lpic_pkg::C_IOX_IN;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_rd_q <= 16'h0;
            ea_q <= 16'h0;
            io_wd_q <= 16'h0;
            io_addr_q <= 11'h0;
            io_stb_q <= 1'b0;
        end else begin
            core_rd_q <= regs_q[ix(cur_q, core_cmd.sel)];
            io_stb_q <= io_op;
            if (op_w == lpic_pkg::C_EA_PRE) begin
                ea_q <= 16'(b_w + core_cmd.data);
            end else if (op_w == lpic_pkg::C_EA_POST) begin
                ea_q <= 16'(core_cmd.data + x_w);
            end
            if (io_op) begin
                io_addr_q <= core_cmd.data[10:0];
                io_wd_q <= a_w;
            end
        end
    end

    // ---------------- read path ----------------
    logic [31:0] rd_w;
    logic rd_ok;
    always_comb begin
        rd_w = 32'h0;
        rd_ok = 1'b1;
        if (s_axi_araddr == `LPIC_A_LVL_SET) begin
            rd_w = {16'h0, act_q};
        end else if (s_axi_araddr == `LPIC_A_LVL_CLR) begin
            rd_w = 32'h0;
        end else if (s_axi_araddr == `LPIC_A_CUR_LVL) begin
            rd_w = {28'h0, cur_q};
        end else if (s_axi_araddr == `LPIC_A_INT_FLAGS) begin
            rd_w = {22'h0, flags_q};
        end else if (s_axi_araddr == `LPIC_A_CTRL) begin
            rd_w = {31'h0, sbe_en_q};
        end else if (s_axi_araddr == `LPIC_A_IDENT) begin
            rd_w = {id_busy_q, 14'h0, id_valid_q, 7'h0, id_code_q};
        end else if (s_axi_araddr == `LPIC_A_REG_PTR) begin
            rd_w = {25'h0, ptr_q};
        end else if (s_axi_araddr == `LPIC_A_REG_DATA) begin
            rd_w = {16'h0, ptr_w};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_w;
            rresp_q <= rd_ok ? 2'h0 : 2'h2;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign cur_lvl = cur_q;
    assign lvl_switch = switch_q;
    assign core_rdata = core_rd_q;
    assign ea_out = ea_q;
    assign io_reg_addr = io_addr_q;
    assign io_wdata = io_wd_q;
    assign io_strobe = io_stb_q;
    assign ident_req = id_req_q;
    assign ident_lvl = id_lvl_q;

    // ---------------- assertions ----------------
    a_top_wins: assert property (@(posedge aclk) disable iff (!aresetn)
        act_q[15] |=> cur_q == 4'hF)
        else $error("level 15 active but not running");
    a_switch_time: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(act_q[14]) && !act_q[15] |-> ##[1:SW_MAX] cur_q == 4'hE)
        else $error("context switch too slow");
    a_sw_activate: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_set |=> (act_q & $past(wd16)) == $past(wd16))
        else $error("software activation lost");
    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        ((flags_q & ~flag_clr) & ~flags_d) == 10'h0)
        else $error("internal flag dropped without clear");
    a_mbe_level: assert property (@(posedge aclk) disable iff (!aresetn)
        mem_mbe |=> flags_q[`LPIC_F_PARITY_ERROR] ##1 act_q[14])
        else $error("multi-bit error did not raise level 14");
    a_jsr_link: assert property (@(posedge aclk) disable iff (!aresetn)
        op_w == lpic_pkg::C_JSR |=> regs_q[ix($past(cur_q), `LPIC_R_L)]
            == 16'($past(p_w) + 16'h1))
        else $error("link not loaded with return address");
    a_seq_ptr: assert property (@(posedge aclk) disable iff (!aresetn)
        op_w == lpic_pkg::C_SEQ && !wr_data |=> regs_q[ix($past(cur_q), `LPIC_R_P)]
            == 16'($past(p_w) + 16'h1))
        else $error("pointer did not advance");
    a_iox_addr: assert property (@(posedge aclk) disable iff (!aresetn)
        io_op |=> io_strobe && io_reg_addr == $past(core_cmd.data[10:0])
            && io_wdata == $past(a_w))
        else $error("I/O address or accumulator wrong");
    a_ea_pre: assert property (@(posedge aclk) disable iff (!aresetn)
        op_w == lpic_pkg::C_EA_PRE |=> ea_q == 16'($past(b_w) + $past(core_cmd.data)))
        else $error("pre-index sum wrong");
    a_ident_done: assert property (@(posedge aclk) disable iff (!aresetn)
        id_busy_q && ack_f |=> !id_req_q && id_valid_q && id_code_q == $past(ident_code))
        else $error("query answer not captured");

endmodule : lpic_top

// file: sim/lpic_io_model.sv
/* lpic_io_model: I/O interface side; answers identity queries, returns
   the inverse of the last word written. Assumes: shares aclk and reset. */
`timescale 1ns/1ps
module lpic_io_model (
    input wire logic aclk, // core clock
    input wire logic aresetn, // reset, active low
    input wire logic ident_req, // query from block
    input wire logic [1:0] ident_lvl, // level queried
    input wire logic io_strobe, // transfer pulse
    input wire logic [15:0] io_wdata, // word from block
    output logic ident_ack, // answer to query
    output logic [8:0] ident_code, // identity, held while ack
    output logic [15:0] io_rdata // interface register
);
    logic [2:0] wait_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_q <= 3'h0;
            ident_ack <= 1'b0;
            ident_code <= 9'h000;
            io_rdata <= 16'h0000;
        end else begin
            wait_q <= (ident_req && !ident_ack) ? wait_q + 3'h1 : 3'h0;
            ident_ack <= ident_req && (ident_ack || wait_q == 3'h3);
            // code toggles while no answer stands
            ident_code <= (ident_ack || wait_q == 3'h3) ? {7'h2C, ident_lvl} : ~ident_code;
            if (io_strobe) io_rdata <= ~io_wdata;
        end
    end
endmodule : lpic_io_model

// file: sim/lpic_top_bench.sv
/* lpic_top_bench: drives the block over AXI4-Lite, core and pins, queues
   expected read results and checks each response against them. Assumes: lpic_io_model answers the far side. */
`timescale 1ns/1ps
module lpic_top_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    lpic_pkg::lpic_core_cmd_s core_cmd = '0;
    logic [9:0] int_cond = 10'h000;
    logic mem_mbe = 1'b0, mem_sbe = 1'b0, top_irq = 1'b0;
    logic [3:0] io_irq = 4'h0;
    wire logic awready, wready, bvalid, arready, rvalid, lvl_switch, io_strobe, ident_req, ident_ack;
    wire logic [1:0] bresp, rresp, ident_lvl;
    wire logic [31:0] rdata;
    wire logic [3:0] cur_lvl;
    wire logic [15:0] core_rdata, ea_out, io_wdata, io_rdata;
    wire logic [10:0] io_reg_addr;
    wire logic [8:0] ident_code;
    logic [33:0] notes [$];
    logic [15:0] vals [6];
    int mismatches = 0, tests_run = 0, k;
    integer seed = 32'hAD98;
    lpic_top lpic_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_cmd(core_cmd),
        .int_cond(int_cond), .mem_mbe(mem_mbe), .mem_sbe(mem_sbe), .io_irq(io_irq),
        .top_irq(top_irq), .ident_ack(ident_ack), .ident_code(ident_code), .io_rdata(io_rdata),
        .cur_lvl(cur_lvl), .lvl_switch(lvl_switch), .core_rdata(core_rdata), .ea_out(ea_out),
        .io_reg_addr(io_reg_addr), .io_wdata(io_wdata), .io_strobe(io_strobe),
        .ident_req(ident_req), .ident_lvl(ident_lvl));
    lpic_io_model lpic_io_model_inst (.aclk(aclk), .aresetn(aresetn), .ident_req(ident_req),
        .ident_lvl(ident_lvl), .io_strobe(io_strobe), .io_wdata(io_wdata),
        .ident_ack(ident_ack), .ident_code(ident_code), .io_rdata(io_rdata));
    initial forever #10 aclk = ~aclk;
    task complete_run();
        if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task tmo();
        mismatches++;
        complete_run();
    endtask : tmo
    task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    always @(posedge aclk) if (rvalid && rready) chk("read", {rresp, rdata}, notes.pop_front());
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 40) tmo();
    endtask : wr
    task rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        notes.push_back(e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 40) tmo();
    endtask : rd
    // pointed register: write or check
    task rr(input logic [6:0] p, input logic [15:0] v, input logic w);
        wr(8'h18, {25'h0, p});
        if (w) wr(8'h1C, {16'h0, v});
        else rd(8'h1C, {18'h0, v});
    endtask : rr
    task core(input lpic_pkg::lpic_op_e op, input logic [2:0] s, input logic [15:0] d);
        @(posedge aclk);
        core_cmd <= '{op, s, d};
        @(posedge aclk);
        core_cmd <= '{lpic_pkg::C_NONE, s, 16'h0000};
        @(posedge aclk);
        #1;
    endtask : core
    task wl(input logic [3:0] l);
        int n;
        for (n = 0; n < 60 && cur_lvl !== l; n++) @(posedge aclk);
        chk("cur_lvl", cur_lvl, l);
        if (n == 60) tmo();
    endtask : wl
    task pm(input logic m, input logic [33:0] e);
        @(posedge aclk);
        mem_mbe <= m;
        mem_sbe <= !m;
        @(posedge aclk);
        mem_mbe <= 1'b0;
        mem_sbe <= 1'b0;
        rd(8'h0C, e);
        wr(8'h0C, 32'h80);
        wr(8'h04, 32'h4000);
    endtask : pm
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 34'h0);
        rd(8'h0C, 34'h0);
        core(lpic_pkg::C_WRITE, 3'h5, 16'h8001);
        chk("core_rdata", core_rdata, 34'h8001);
        core(lpic_pkg::C_WRITE, 3'h1, 16'h4000);
        core(lpic_pkg::C_DSHL, 3'h0, 16'h0000);
        rr(7'h05, 16'h0002, 1'b0);
        rr(7'h01, 16'h8000, 1'b0);
        core(lpic_pkg::C_BRANCH, 3'h0, 16'h0100);
        core(lpic_pkg::C_SEQ, 3'h0, 16'h0000);
        core(lpic_pkg::C_JSR, 3'h0, 16'h0200);
        rr(7'h02, 16'h0200, 1'b0);
        rr(7'h04, 16'h0102, 1'b0);
        core(lpic_pkg::C_WRITE, 3'h3, 16'h0010);
        core(lpic_pkg::C_WRITE, 3'h7, 16'h0003);
        core(lpic_pkg::C_EA_PRE, 3'h0, 16'h0100);
        chk("ea_out", ea_out, 34'h0110);
        core(lpic_pkg::C_EA_POST, 3'h0, 16'h0200);
        chk("ea_out", ea_out, 34'h0203);
        core(lpic_pkg::C_IOX_OUT, 3'h0, 16'hFC12);
        chk("io_reg_addr", io_reg_addr, 34'h412);
        chk("io_wdata", io_wdata, 34'h0002);
        core(lpic_pkg::C_IOX_IN, 3'h5, 16'h0007);
        chk("core_rdata", core_rdata, 34'hFFFD);
        rr(7'h05, 16'hFFFD, 1'b0);
        for (k = 0; k < 6; k++) begin
            vals[k] = $random(seed);
            rr({k[3:0] + 4'h1, k[2:0] + 3'h1}, vals[k], 1'b1);
        end
        for (k = 0; k < 6; k++) rr({k[3:0] + 4'h1, k[2:0] + 3'h1}, vals[k], 1'b0);
        for (k = 0; k < 16; k++) begin
            wr(8'h00, 32'h1 << k);
            rd(8'h08, k);
        end
        wr(8'h04, 32'h8000);
        rd(8'h08, 34'hE);
        wr(8'h04, 32'hFFFF);
        wl(4'h0);
        for (k = 0; k < 10; k++) begin
            @(posedge aclk);
            int_cond <= 10'h001 << k;
            @(posedge aclk);
            int_cond <= 10'h000;
            wl(4'hE);
            chk("lvl_switch", lvl_switch, 34'h1);
            rd(8'h0C, 34'h1 << k);
            wr(8'h0C, 32'h1 << k);
            wr(8'h04, 32'h4000);
            wl(4'h0);
        end
        pm(1'b1, 34'h80);
        pm(1'b0, 34'h0);
        wr(8'h10, 32'h1);
        pm(1'b0, 34'h80);
        for (k = 0; k < 4; k++) begin
            @(posedge aclk);
            io_irq <= 4'h1 << k;
            wl(4'hA + k[3:0]);
        end
        top_irq <= 1'b1;
        wl(4'hF);
        top_irq <= 1'b0;
        io_irq <= 4'h0;
        // pins must be seen low before the clear sticks
        repeat (6) @(posedge aclk);
        wr(8'h04, 32'hFFFF);
        wl(4'h0);
        wr(8'h14, 32'h2);
        for (k = 0; k < 40 && !ident_req; k++) @(posedge aclk);
        for (; k < 80 && ident_req; k++) @(posedge aclk);
        if (k == 80) tmo();
        rd(8'h14, 34'h000100B2);
        rd(8'h40, {2'b10, 32'h0});
        @(posedge aclk);
        complete_run();
    end
endmodule : lpic_top_bench
